// *** src/fntc_map.svh ***
// Register map, field positions, reset values of the fan table/config block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef FNTC_MAP_SVH
`define FNTC_MAP_SVH

`define FNTC_ADDR_CONFIG     8'h03
`define FNTC_ADDR_CONFIG_ALT 8'h09
`define FNTC_ADDR_ONESHOT    8'h0F
`define FNTC_ADDR_HYST       8'h4F
`define FNTC_ADDR_TH7        8'h5C
`define FNTC_ADDR_DUTY7      8'h5D
`define FNTC_ADDR_TH8        8'h5E
`define FNTC_ADDR_DUTY8      8'h5F

`define FNTC_CFG_MASK_BIT    7
`define FNTC_CFG_HOLD_BIT    6
`define FNTC_CFG_FANOFF_BIT  5
`define FNTC_CFG_FILTER_BIT  0

`define FNTC_RST_CONFIG      4'h0
`define FNTC_RST_HYST        5'h04
`define FNTC_RST_TH          7'h7F
`define FNTC_RST_DUTY        6'h3F
`define FNTC_FAULT_RUN       2'h2

`endif

// *** src/fntc_pkg.sv ***
// Types shared by the fan table/config block
package fntc_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fntc_req_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] temp;
        logic       out_of_limit;
    } fntc_result_t;

    typedef struct packed {
        logic mask;
        logic hold;
        logic fanoff;
        logic filter;
    } fntc_cfg_t;

    typedef enum logic [1:0] {
        FNTC_SEL_LOW = 2'h0,
        FNTC_SEL_E7  = 2'h1,
        FNTC_SEL_E8  = 2'h3
    } fntc_sel_t;

endpackage

// *** src/fntc_regs.sv ***
// Fan table upper entries, hysteresis and configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "fntc_map.svh"

module fntc_regs (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire fntc_pkg::fntc_req_t   req,
    output var  logic [7:0]            rdata,
    input  wire fntc_pkg::fntc_result_t result,
    input  wire logic                  conv_busy,
    output var  logic                  conv_start,
    input  wire logic [5:0]            lower_duty,
    output var  logic [5:0]            fan_duty,
    input  wire logic                  pwm_in,
    input  wire logic                  pwm_active_high,
    output var  logic                  pwm_out,
    input  wire logic                  alert_clear,
    output var  logic                  alert_o,
    output var  logic                  alert_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fntc_pkg::fntc_cfg_t cfg_r,      cfg_nxt;
    logic [4:0]          hyst_r,     hyst_nxt;
    logic [6:0]          th7_r,      th7_nxt;
    logic [6:0]          th8_r,      th8_nxt;
    logic [5:0]          duty7_r,    duty7_nxt;
    logic [5:0]          duty8_r,    duty8_nxt;
    fntc_pkg::fntc_sel_t sel_r,      sel_nxt;
    logic [1:0]          fault_r,    fault_nxt;
    logic                alert_r,    alert_nxt;
    logic                start_r,    start_nxt;
    logic [7:0]          rdata_r,    rdata_nxt;
    logic [5:0]          duty_r,     duty_nxt;
    logic                pwm_r,      pwm_nxt;
    logic                aoe_r,      aoe_nxt;

    logic       wr_cfg;
    logic       oneshot_wr;
    logic       up7;
    logic       up8;
    logic       down7;
    logic       down8;
    logic       fault_event;
    logic [7:0] t_plus_h;

    assign wr_cfg     = req.wr && (req.addr == `FNTC_ADDR_CONFIG ||
                                   req.addr == `FNTC_ADDR_CONFIG_ALT);
    assign oneshot_wr = req.wr && (req.addr == `FNTC_ADDR_ONESHOT);
    assign t_plus_h   = {1'b0, result.temp} + {3'h0, hyst_r};
    assign up7        = result.temp > th7_r;
    assign up8        = result.temp > th8_r;
    assign down7      = t_plus_h < {1'b0, th7_r};
    assign down8      = t_plus_h < {1'b0, th8_r};
    // Filter set: third consecutive miss and every one after it
    assign fault_event = result.valid && result.out_of_limit &&
                         (!cfg_r.filter || fault_r >= `FNTC_FAULT_RUN);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        cfg_nxt   = cfg_r;
        hyst_nxt  = hyst_r;
        th7_nxt   = th7_r;
        th8_nxt   = th8_r;
        duty7_nxt = duty7_r;
        duty8_nxt = duty8_r;
        sel_nxt   = sel_r;
        fault_nxt = fault_r;
        rdata_nxt = 8'h00;

        if (wr_cfg) begin
            cfg_nxt.mask   = req.wdata[`FNTC_CFG_MASK_BIT];
            cfg_nxt.hold   = req.wdata[`FNTC_CFG_HOLD_BIT];
            cfg_nxt.fanoff = req.wdata[`FNTC_CFG_FANOFF_BIT];
            cfg_nxt.filter = req.wdata[`FNTC_CFG_FILTER_BIT];
        end
        if (req.wr) begin
            unique case (req.addr)
                `FNTC_ADDR_HYST:  hyst_nxt  = req.wdata[4:0];
                `FNTC_ADDR_TH7:   th7_nxt   = req.wdata[6:0];
                `FNTC_ADDR_TH8:   th8_nxt   = req.wdata[6:0];
                `FNTC_ADDR_DUTY7: duty7_nxt = req.wdata[5:0];
                `FNTC_ADDR_DUTY8: duty8_nxt = req.wdata[5:0];
                default: ;
            endcase
        end

        // Unused bits padded with zero
        if (req.rd) begin
            unique case (req.addr)
                `FNTC_ADDR_CONFIG: rdata_nxt = {cfg_r.mask, cfg_r.hold,
                    cfg_r.fanoff, 4'h0, cfg_r.filter};
                `FNTC_ADDR_HYST:  rdata_nxt = {3'h0, hyst_r};
                `FNTC_ADDR_TH7:   rdata_nxt = {1'b0, th7_r};
                `FNTC_ADDR_TH8:   rdata_nxt = {1'b0, th8_r};
                `FNTC_ADDR_DUTY7: rdata_nxt = {2'h0, duty7_r};
                `FNTC_ADDR_DUTY8: rdata_nxt = {2'h0, duty8_r};
                default:          rdata_nxt = 8'h00;
            endcase
        end

        // Table moves only on a fresh remote result
        if (result.valid) begin
            unique case (sel_r)
                fntc_pkg::FNTC_SEL_LOW: begin
                    if (up8) begin
                        sel_nxt = fntc_pkg::FNTC_SEL_E8;
                    end else if (up7) begin
                        sel_nxt = fntc_pkg::FNTC_SEL_E7;
                    end
                end
                fntc_pkg::FNTC_SEL_E7: begin
                    if (up8) begin
                        sel_nxt = fntc_pkg::FNTC_SEL_E8;
                    end else if (down7) begin
                        sel_nxt = fntc_pkg::FNTC_SEL_LOW;
                    end
                end
                fntc_pkg::FNTC_SEL_E8: begin
                    if (down8 && down7) begin
                        sel_nxt = fntc_pkg::FNTC_SEL_LOW;
                    end else if (down8) begin
                        sel_nxt = fntc_pkg::FNTC_SEL_E7;
                    end
                end
                default: sel_nxt = fntc_pkg::FNTC_SEL_LOW;
            endcase

            if (!result.out_of_limit) begin
                fault_nxt = 2'h0;
            end else if (fault_r != 2'h3) begin
                fault_nxt = fault_r + 2'h1;
            end
        end

        unique case (sel_r)
            fntc_pkg::FNTC_SEL_E8: duty_nxt = duty8_r;
            fntc_pkg::FNTC_SEL_E7: duty_nxt = duty7_r;
            default:               duty_nxt = lower_duty;
        endcase

        // Set wins over a clear arriving in the same cycle
        alert_nxt = fault_event || (alert_r && !alert_clear);
        // Pin driven low only while unmasked
        aoe_nxt = alert_nxt && !cfg_nxt.mask;

        // Running: restart as soon as the converter is idle
        if (!cfg_r.hold) begin
            start_nxt = !conv_busy && !start_r;
        end else begin
            start_nxt = oneshot_wr;
        end

        if (cfg_r.hold && cfg_r.fanoff) begin
            pwm_nxt = !pwm_active_high;
        end else begin
            pwm_nxt = pwm_in;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r   <= `FNTC_RST_CONFIG;
            hyst_r  <= `FNTC_RST_HYST;
            th7_r   <= `FNTC_RST_TH;
            th8_r   <= `FNTC_RST_TH;
            duty7_r <= `FNTC_RST_DUTY;
            duty8_r <= `FNTC_RST_DUTY;
            sel_r   <= fntc_pkg::FNTC_SEL_LOW;
            fault_r <= 2'h0;
            alert_r <= 1'b0;
            start_r <= 1'b0;
            rdata_r <= 8'h00;
            duty_r  <= 6'h00;
            pwm_r   <= 1'b0;
            aoe_r   <= 1'b0;
        end else begin
            cfg_r   <= cfg_nxt;
            hyst_r  <= hyst_nxt;
            th7_r   <= th7_nxt;
            th8_r   <= th8_nxt;
            duty7_r <= duty7_nxt;
            duty8_r <= duty8_nxt;
            sel_r   <= sel_nxt;
            fault_r <= fault_nxt;
            alert_r <= alert_nxt;
            start_r <= start_nxt;
            rdata_r <= rdata_nxt;
            duty_r  <= duty_nxt;
            pwm_r   <= pwm_nxt;
            aoe_r   <= aoe_nxt;
        end
    end

    assign rdata      = rdata_r;
    assign conv_start = start_r;
    assign fan_duty   = duty_r;
    assign pwm_out    = pwm_r;
    assign alert_o    = 1'b0;
    assign alert_oe   = aoe_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_mask_release: assert property (@(posedge clk) disable iff (!resetn)
        cfg_r.mask |-> !alert_oe)
        else $error("alert pin driven while masked");

    a_unused_zero: assert property (@(posedge clk) disable iff (!resetn)
        $past(req.rd) && ($past(req.addr) == `FNTC_ADDR_TH8 ||
        $past(req.addr) == `FNTC_ADDR_TH7) |-> rdata[7] == 1'b0)
        else $error("threshold upper bit reads nonzero");

    a_cfg_alt_rd: assert property (@(posedge clk) disable iff (!resetn)
        req.rd && req.addr == `FNTC_ADDR_CONFIG_ALT |=> rdata == 8'h00)
        else $error("alternate config address readable");

    a_conv_running: assert property (@(posedge clk) disable iff (!resetn)
        !cfg_r.hold && !conv_busy && !conv_start |=> conv_start)
        else $error("idle converter not restarted");

    a_conv_stopped: assert property (@(posedge clk) disable iff (!resetn)
        $past(cfg_r.hold) && !$past(oneshot_wr) |-> !conv_start)
        else $error("conversion started in low power");

    a_oneshot_go: assert property (@(posedge clk) disable iff (!resetn)
        cfg_r.hold && oneshot_wr |=> conv_start ##1
        (!conv_start || $past(oneshot_wr)))
        else $error("one-shot write did not start one cycle");

    a_pwm_forced: assert property (@(posedge clk) disable iff (!resetn)
        cfg_r.hold && cfg_r.fanoff |=> pwm_out == !$past(pwm_active_high))
        else $error("pwm not at disabled level");

    a_pwm_pass: assert property (@(posedge clk) disable iff (!resetn)
        !(cfg_r.hold && cfg_r.fanoff) |=> pwm_out == $past(pwm_in))
        else $error("pwm not passed through");

    a_fault_single: assert property (@(posedge clk)
        disable iff (!resetn)
        !cfg_r.filter && result.valid && result.out_of_limit |=> alert_r)
        else $error("single fault not flagged");

    a_fault_queue: assert property (@(posedge clk) disable iff (!resetn)
        cfg_r.filter && result.valid && result.out_of_limit &&
        fault_r < 2'h2 && !alert_r |=> !alert_r)
        else $error("filtered fault flagged too early");

    a_duty_eight: assert property (@(posedge clk) disable iff (!resetn)
        sel_r == fntc_pkg::FNTC_SEL_E8 |=> fan_duty == $past(duty8_r))
        else $error("entry 8 duty not applied");

    a_hyst_hold: assert property (@(posedge clk) disable iff (!resetn)
        sel_r == fntc_pkg::FNTC_SEL_E7 && result.valid && !up8 &&
        !down7 |=> sel_r == fntc_pkg::FNTC_SEL_E7)
        else $error("table stepped down inside hysteresis");

    a_duty_seven: assert property (@(posedge clk) disable iff (!resetn)
        sel_r == fntc_pkg::FNTC_SEL_E7 |=> fan_duty == $past(duty7_r))
        else $error("entry 7 duty not applied");

    // Sampled reset keeps the release edge out, flops still see reset there
    a_duty_lower: assert property (@(posedge clk) disable iff (!resetn)
        resetn && sel_r == fntc_pkg::FNTC_SEL_LOW |=>
        fan_duty == $past(lower_duty))
        else $error("lower table duty not applied");

    a_cfg_unused: assert property (@(posedge clk) disable iff (!resetn)
        $past(req.rd) && $past(req.addr) == `FNTC_ADDR_CONFIG |->
        rdata[4:1] == 4'h0)
        else $error("config unused bits read nonzero");

    a_duty_unused: assert property (@(posedge clk) disable iff (!resetn)
        $past(req.rd) && ($past(req.addr) == `FNTC_ADDR_DUTY7 ||
        $past(req.addr) == `FNTC_ADDR_DUTY8) |->
        rdata[7:6] == 2'h0)
        else $error("duty upper bits read nonzero");

    a_table_up: assert property (@(posedge clk) disable iff (!resetn)
        result.valid && result.temp > th8_r |=>
        sel_r == fntc_pkg::FNTC_SEL_E8)
        else $error("table did not climb to entry 8");

    a_table_e7: assert property (@(posedge clk) disable iff (!resetn)
        sel_r == fntc_pkg::FNTC_SEL_LOW && result.valid &&
        result.temp > th7_r && result.temp <= th8_r |=>
        sel_r == fntc_pkg::FNTC_SEL_E7)
        else $error("table did not climb to entry 7");

    a_fault_third: assert property (@(posedge clk) disable iff (!resetn)
        cfg_r.filter && result.valid && result.out_of_limit &&
        fault_r == 2'h2 |=> alert_r)
        else $error("third filtered fault not flagged");

    a_alert_clear: assert property (@(posedge clk) disable iff (!resetn)
        alert_clear && !(result.valid && result.out_of_limit) |=> !alert_r)
        else $error("alert not cleared");

    a_alert_pin: assert property (@(posedge clk) disable iff (!resetn)
        alert_r && !cfg_r.mask |-> alert_oe)
        else $error("unmasked alert not driven");

    a_fault_reset: assert property (@(posedge clk) disable iff (!resetn)
        result.valid && !result.out_of_limit |=> fault_r == 2'h0)
        else $error("fault run not restarted");

endmodule
`default_nettype wire

// *** verification/fntc_host.sv ***
// Register-bus host model issuing single-byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module fntc_host (
    input  wire logic          clk,
    output var  fntc_pkg::fntc_req_t req
);
    initial req = '0;

    // Released address and data show junk, never the last transfer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule
`default_nettype wire

// *** verification/fntc_regs_test.sv ***
// Self-checking bench for the fan table and configuration registers
`timescale 1ns/1ps
`default_nettype none
module fntc_regs_test;
    logic                   clk = 1'b0;
    logic                   resetn = 1'b0;
    fntc_pkg::fntc_req_t    req;
    fntc_pkg::fntc_result_t result = '0;
    logic                   conv_busy = 1'b1;
    logic [5:0]             lower_duty = 6'h05;
    logic                   pwm_in = 1'b0;
    logic                   pwm_hi = 1'b1;
    logic                   alert_clear = 1'b0;
    logic [7:0]             rdata;
    logic                   conv_start;
    logic [5:0]             fan_duty;
    logic                   pwm_out;
    logic                   alert_o;
    logic                   alert_oe;
    logic [7:0]             expq[$];
    logic                   rd_d = 1'b0;
    logic [7:0]             d;
    int                     fails = 0;
    int                     checked = 0;
    int                     starts = 0;
    int                     s0;
    logic [7:0]             ra[8] = '{8'h03, 8'h09, 8'h4F, 8'h5C,
                                      8'h5D, 8'h5E, 8'h5F, 8'h20};
    logic [7:0]             rv[8] = '{8'h00, 8'h00, 8'h04, 8'h7F,
                                      8'h3F, 8'h7F, 8'h3F, 8'h00};
    logic [7:0]             rm[8] = '{8'hE1, 8'h00, 8'h1F, 8'h7F,
                                      8'h3F, 8'h7F, 8'h3F, 8'h00};
    logic [7:0]             pc[4] = '{8'h20, 8'h40, 8'h60, 8'h60};
    logic [5:0]             pat = 6'b111011;
    logic                   pe;

    always #2 clk = ~clk;

    fntc_host fntc_host_i (.clk(clk), .req(req));
    fntc_regs fntc_regs_i (
        .clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
        .result(result), .conv_busy(conv_busy), .conv_start(conv_start),
        .lower_duty(lower_duty), .fan_duty(fan_duty), .pwm_in(pwm_in),
        .pwm_active_high(pwm_hi), .pwm_out(pwm_out),
        .alert_clear(alert_clear), .alert_o(alert_o), .alert_oe(alert_oe)
    );

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] exp,
                         input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    always @(posedge clk)
        rd_d <= req.rd;

    // Read data stands one cycle, so it is taken mid-cycle
    always @(negedge clk) begin
        if (rd_d === 1'b1)
            check("rdata", expq.pop_front(), rdata);
        if (conv_start === 1'b1)
            starts++;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        fntc_host_i.xfer(1'b1, a, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        fntc_host_i.xfer(1'b0, a, 8'h00);
    endtask

    task automatic conv(input logic [6:0] t, input logic oor);
        @(posedge clk);
        result <= '{valid: 1'b1, temp: t, out_of_limit: oor};
        @(posedge clk);
        result <= '{valid: 1'b0, temp: ~t, out_of_limit: ~oor};
    endtask

    task automatic duty(input logic [6:0] t, input logic [5:0] e);
        conv(t, 1'b0);
        repeat (2) @(posedge clk);
        #1 check("fan_duty", {2'h0, e}, {2'h0, fan_duty});
    endtask

    task automatic alert_after(input logic oor, input logic e);
        conv(7'h20, oor);
        @(posedge clk);
        #1 check("alert_oe", {7'h0, e}, {7'h0, alert_oe});
    endtask

    task automatic clear_alert();
        @(posedge clk);
        alert_clear <= 1'b1;
        @(posedge clk);
        alert_clear <= 1'b0;
        @(posedge clk);
        #1 check("alert_oe", 8'h00, {7'h0, alert_oe});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #40000;
        fails++;
        end_sim();
    end

    initial begin
        void'($urandom(97629));
        @(posedge clk);
        lower_duty <= 6'($urandom);
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(ra[i], rv[i]);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom) | 8'hE0;
            wr(ra[i], d);
            rd(ra[i], d & rm[i]);
            if (i < 2)
                rd(8'h03, d & 8'hE1);
        end
        wr(8'h03, 8'h00);
        wr(8'h4F, 8'h04);
        wr(8'h5C, 8'h28);
        wr(8'h5D, 8'h15);
        wr(8'h5E, 8'h3C);
        wr(8'h5F, 8'h2A);
        duty(7'd40, lower_duty);
        duty(7'd50, 6'h15);
        duty(7'd61, 6'h2A);
        duty(7'd59, 6'h2A);
        duty(7'd55, 6'h15);
        duty(7'd36, 6'h15);
        duty(7'd35, lower_duty);
        alert_after(1'b0, 1'b0);
        alert_after(1'b1, 1'b1);
        check("alert_o", 8'h00, {7'h0, alert_o});
        clear_alert();
        wr(8'h03, 8'h80);
        alert_after(1'b1, 1'b0);
        wr(8'h03, 8'h01);
        repeat (2) @(posedge clk);
        #1 check("alert_oe", 8'h01, {7'h0, alert_oe});
        clear_alert();
        // This in-limit result clears the two earlier misses; a later in-limit result ends the run
        alert_after(1'b0, 1'b0);
        for (int i = 0; i < 6; i++)
            alert_after(pat[i], i == 5);
        clear_alert();
        wr(8'h03, 8'h00);
        s0 = starts;
        conv_busy <= 1'b0;
        repeat (4) @(posedge clk);
        check("conv running", 8'h01, {7'h0, starts > s0});
        wr(8'h03, 8'h40);
        repeat (2) @(posedge clk);
        s0 = starts;
        repeat (10) @(posedge clk);
        check("standby starts", 8'h00, 8'(starts - s0));
        for (int k = 0; k < 2; k++) begin
            conv_busy <= k[0];
            s0 = starts;
            wr(8'h0F, 8'($urandom));
            repeat (3) @(posedge clk);
            check("one-shot starts", 8'h01, 8'(starts - s0));
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h03, pc[k]);
            @(posedge clk);
            pwm_hi <= k[0];
            for (int j = 0; j < 4; j++) begin
                @(posedge clk);
                pwm_in <= 1'($urandom);
                @(posedge clk);
                pe = (k > 1) ? ~pwm_hi : pwm_in;
                #1 check("pwm_out", {7'h0, pe}, {7'h0, pwm_out});
            end
        end
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule
`default_nettype wire
